/* logic/sgc_pkg.sv */
package sgc_pkg;
    // Timing: programming time is a plain default, shorten for simulation
    localparam int CLK_PERIOD_NS = 40;
    localparam int NV_PROG_TIME_NS = 40000;
    localparam int NV_PROG_CYCLES = (NV_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [6:0] OFS_ID = 7'h00;
    localparam logic [6:0] OFS_GEN = 7'h01;
    localparam logic [6:0] OFS_OUT1 = 7'h02;
    localparam logic [6:0] OFS_DIVLO = 7'h03;
    localparam logic [6:0] OFS_SEL = 7'h04;
    localparam logic [6:0] OFS_XCAP = 7'h05;
    localparam logic [6:0] OFS_BCNT = 7'h06;
    localparam int REG_FIRST = 1;
    localparam int REG_LAST = 6;

    // Field positions
    localparam int GEN_BUSY_BIT = 6;
    localparam int GEN_LOCK_BIT = 5;
    localparam int GEN_PWDN_BIT = 4;
    localparam int GEN_INCLK_HI = 3;
    localparam int GEN_INCLK_LO = 2;
    localparam int GEN_ADDR_HI = 1;
    localparam int GEN_ADDR_LO = 0;
    localparam int OUT1_SRC_BIT = 7;
    localparam int OUT1_PINSEL_BIT = 6;
    localparam int OUT1_ST1_HI = 5;
    localparam int OUT1_ST1_LO = 4;
    localparam int OUT1_ST0_HI = 3;
    localparam int OUT1_ST0_LO = 2;
    localparam int OUT1_DIVHI_HI = 1;
    localparam int OUT1_DIVHI_LO = 0;
    localparam int XCAP_HI = 7;
    localparam int XCAP_LO = 3;
    localparam int BCNT_HI = 7;
    localparam int BCNT_LO = 1;
    localparam int TRIG_BIT = 0;
    localparam int CMD_BYTE_BIT = 7;

    // Reset values, one byte per bank register, offset 6 first
    localparam logic [REG_LAST:REG_FIRST][7:0] BANK_RST = {
        8'h60, 8'h50, 8'h00, 8'h01, 8'hB4, 8'h00};
    // Writable bits: reserved and status bits drop on write
    localparam logic [7:0] MASK_GEN = 8'h3F;
    localparam logic [7:0] MASK_XCAP = 8'hF8;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [4:0] LOAD_CAP_MAX = 5'h14;

    // Serial engine constants
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [3:0] PIN_SYNC_RST = 4'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK = 4'h3,
        ST_RX = 4'h2,
        ST_TX = 4'h6,
        ST_RACK = 4'h7
    } sgc_bus_state_t;

    typedef enum logic [1:0] {
        MODE_PWDN = 2'h0,
        MODE_HIZ = 2'h1,
        MODE_LOW = 2'h2,
        MODE_ON = 2'h3
    } sgc_out_mode_t;

    typedef struct packed {
        logic source_pll;
        sgc_out_mode_t mode;
        logic power_down;
        logic [9:0] divider;
        logic divider_run;
        logic [4:0] load_cap_pf;
        logic [1:0] input_clk_sel;
    } sgc_cfg_t;

    // Writable-bit mask per offset
    function automatic logic [7:0] wr_mask(input logic [6:0] ofs);
        if (ofs == OFS_GEN) begin
            return MASK_GEN;
        end else if (ofs == OFS_XCAP) begin
            return MASK_XCAP;
        end else if (ofs >= OFS_OUT1 && ofs <= OFS_BCNT) begin
            return MASK_ALL;
        end
        return MASK_NONE;
    endfunction
endpackage

/* logic/sgc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Raw pins and filtered levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q; // Three stages and result
    logic [WIDTH-1:0] lvl_d;

    // Level only moves once stages two and three agree
    always_comb begin
        lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end

    // First stage feeds only the second
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule // sgc_pin_sync
`default_nettype wire

/* logic/sgc_config_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Low two address bits from generic byte
// - Source bit picks input clock or PLL
// - Pin select: serial pins or control pins
// - Pin select acts only from stored copy
// - Grounded supply forces serial pins, address zero
// - State codes: off, high-z, low, on
// - Ten-bit divider, zero holds in reset
// - Setting bit chooses state0 or state1
// - Three control inputs pick the setting outside serial mode; only one in it
// - Load code 1 pF steps, clamp 20
// - Count field sets block read length
// - Rising trigger edge starts store cycle
// - Reads keep working while storing
// - Stored lock refuses further storing
// - Lock acts only once stored
// - Bytes travel most significant bit first
// - Status bit high while storing
module sgc_config_bank #(
    parameter int NV_PROG_CYCLES = sgc_pkg::NV_PROG_CYCLES,
    parameter logic [4:0] DEV_ADDR_HI = 5'h0A, // Arbitrary value
    parameter logic [3:0] VENDOR_ID = 4'h6, // Arbitrary value
    parameter logic [2:0] REVISION_ID = 3'h2, // Arbitrary value
    parameter logic VARIANT_ID = 1'b0 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pins
    input wire logic ctrl_in0_in,
    input wire logic pin14_in,
    input wire logic pin15_in,
    input wire logic output_supply_gnd_in,
    output logic pin15_out,
    output logic pin15_oe_out,
    // Configuration and status
    output var sgc_pkg::sgc_cfg_t cfg_out,
    output logic [2:0] ctrl_setting_out,
    output logic serial_mode_out,
    output logic nv_prog_in_progress_out
);
    localparam int CW = $clog2(NV_PROG_CYCLES + 1);
    localparam logic [CW-1:0] PROG_LOAD = CW'(NV_PROG_CYCLES);
    localparam logic [CW-1:0] PROG_LAST = CW'(1);

    // Synchronised pins
    logic [3:0] pins;
    logic supply_gnd, ctrl0, pin15, pin14;
    sgc_pin_sync #(.WIDTH(4), .RST_VAL(sgc_pkg::PIN_SYNC_RST)) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in({output_supply_gnd_in, ctrl_in0_in, pin15_in, pin14_in}),
        .level_out(pins)
    );
    assign {supply_gnd, ctrl0, pin15, pin14} = pins;

    // Working bank, stored copy and store engine
    logic [sgc_pkg::REG_LAST:sgc_pkg::REG_FIRST][7:0] reg_q, reg_d;
    logic [sgc_pkg::REG_LAST:sgc_pkg::REG_FIRST][7:0] nv_q, nv_d;
    logic busy_q, busy_d;
    logic trig_prev_q, trig_prev_d;
    logic [CW-1:0] prog_cnt_q, prog_cnt_d;
    logic trig, nv_lock, prog_start;

    // Serial engine
    sgc_pkg::sgc_bus_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [6:0] offset_q, offset_d, remain_q, remain_d;
    logic rw_q, rw_d, cmd_seen_q, cmd_seen_d, block_q, block_d;
    logic count_sent_q, count_sent_d, drive_q, drive_d, nack_q, nack_d;
    logic scl_prev_q, sda_prev_q;
    logic scl, sda, scl_rise, scl_fall, bus_start, bus_stop;
    logic serial_mode, load_tx, wr_en;
    logic [6:0] dev_addr;
    logic [7:0] tx_byte;

    // Output configuration
    sgc_pkg::sgc_cfg_t cfg_q, cfg_d;
    logic [2:0] setting;
    logic [1:0] state_def;

    // Read value of one offset; live during a store cycle as well
    function automatic logic [7:0] rd_byte(input logic [6:0] ofs);
        if (ofs == sgc_pkg::OFS_ID) begin
            return {VARIANT_ID, REVISION_ID, VENDOR_ID};
        end else if (ofs == sgc_pkg::OFS_GEN) begin
            return {1'b0, busy_q, reg_q[sgc_pkg::REG_FIRST][5:0]};
        end else if (ofs <= sgc_pkg::OFS_BCNT) begin
            return reg_q[ofs[2:0]];
        end
        return 8'h00;
    endfunction

    // Pin function comes from the stored copy; grounded supply overrides
    assign serial_mode = supply_gnd | ~nv_q[sgc_pkg::OFS_OUT1][sgc_pkg::OUT1_PINSEL_BIT];
    assign scl = serial_mode ? pin14 : 1'b1;
    assign sda = serial_mode ? pin15 : 1'b1;
    assign scl_rise = scl & ~scl_prev_q;
    assign scl_fall = ~scl & scl_prev_q;
    assign bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
    assign bus_stop = scl & scl_prev_q & ~sda_prev_q & sda;
    // Address low bits cleared while supply is grounded
    assign dev_addr = {DEV_ADDR_HI, supply_gnd ? 2'b00 :
        reg_q[sgc_pkg::REG_FIRST][sgc_pkg::GEN_ADDR_HI:sgc_pkg::GEN_ADDR_LO]};

    // Next byte to send: count first on a block read, then data
    always_comb begin
        if (block_q && !count_sent_q) begin
            tx_byte = {1'b0, reg_q[sgc_pkg::OFS_BCNT][sgc_pkg::BCNT_HI:sgc_pkg::BCNT_LO]};
        end else if (block_q && remain_q == 7'h00) begin
            tx_byte = sgc_pkg::IDLE_BYTE;
        end else begin
            tx_byte = rd_byte(offset_q);
        end
    end

    // Serial engine next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        offset_d = offset_q;
        remain_d = remain_q;
        rw_d = rw_q;
        cmd_seen_d = cmd_seen_q;
        block_d = block_q;
        count_sent_d = count_sent_q;
        drive_d = drive_q;
        nack_d = nack_q;
        load_tx = 1'b0;
        wr_en = 1'b0;
        if (bus_start) begin
            // Repeated start keeps the offset for a read
            state_d = sgc_pkg::ST_ADDR;
            cnt_d = 4'h0;
            drive_d = 1'b0;
        end else if (bus_stop) begin
            state_d = sgc_pkg::ST_IDLE;
            cmd_seen_d = 1'b0;
            drive_d = 1'b0;
        end else begin
            unique case (state_q)
                sgc_pkg::ST_IDLE: begin
                    drive_d = 1'b0;
                end
                sgc_pkg::ST_ADDR, sgc_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == sgc_pkg::BYTE_BITS) begin
                        state_d = sgc_pkg::ST_ACK;
                        drive_d = 1'b1;
                        if (state_q == sgc_pkg::ST_ADDR) begin
                            rw_d = shift_q[0];
                            if (shift_q[7:1] != dev_addr) begin
                                // Not ours: stay off the bus
                                state_d = sgc_pkg::ST_IDLE;
                                drive_d = 1'b0;
                            end
                        end else if (!cmd_seen_q) begin
                            cmd_seen_d = 1'b1;
                            block_d = ~shift_q[sgc_pkg::CMD_BYTE_BIT];
                            offset_d = shift_q[6:0];
                            count_sent_d = 1'b0;
                        end else begin
                            wr_en = 1'b1;
                            offset_d = 7'(offset_q + 7'h01);
                        end
                    end
                end
                sgc_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        drive_d = 1'b0;
                        if (rw_q) begin
                            load_tx = 1'b1;
                        end else begin
                            state_d = sgc_pkg::ST_RX;
                        end
                    end
                end
                sgc_pkg::ST_TX: begin
                    if (scl_fall) begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == sgc_pkg::LAST_BIT) begin
                            state_d = sgc_pkg::ST_RACK;
                            drive_d = 1'b0;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drive_d = ~shift_q[6];
                        end
                    end
                end
                sgc_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        nack_d = sda;
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (nack_q) begin
                            state_d = sgc_pkg::ST_IDLE;
                        end else begin
                            load_tx = 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = sgc_pkg::ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
        // Load a byte and drive its first bit
        if (load_tx) begin
            state_d = sgc_pkg::ST_TX;
            shift_d = tx_byte;
            drive_d = ~tx_byte[7];
            if (block_q && !count_sent_q) begin
                count_sent_d = 1'b1;
                remain_d = reg_q[sgc_pkg::OFS_BCNT][sgc_pkg::BCNT_HI:sgc_pkg::BCNT_LO];
            end else if (!block_q || remain_q != 7'h00) begin
                offset_d = 7'(offset_q + 7'h01);
                remain_d = block_q ? 7'(remain_q - 7'h01) : remain_q;
            end
        end
    end

    // Serial engine registers
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= sgc_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            offset_q <= 7'h00;
            remain_q <= 7'h00;
            rw_q <= 1'b0;
            cmd_seen_q <= 1'b0;
            block_q <= 1'b0;
            count_sent_q <= 1'b0;
            drive_q <= 1'b0;
            nack_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            offset_q <= offset_d;
            remain_q <= remain_d;
            rw_q <= rw_d;
            cmd_seen_q <= cmd_seen_d;
            block_q <= block_d;
            count_sent_q <= count_sent_d;
            drive_q <= drive_d;
            nack_q <= nack_d;
            scl_prev_q <= scl;
            sda_prev_q <= sda;
        end
    end

    assign trig = reg_q[sgc_pkg::OFS_BCNT][sgc_pkg::TRIG_BIT];
    assign nv_lock = nv_q[sgc_pkg::OFS_GEN][sgc_pkg::GEN_LOCK_BIT];
    assign prog_start = trig & ~trig_prev_q & ~nv_lock & ~busy_q;

    // Bank writes and store cycle next state
    always_comb begin
        reg_d = reg_q;
        nv_d = nv_q;
        busy_d = busy_q;
        prog_cnt_d = prog_cnt_q;
        trig_prev_d = trig;
        // Writes while storing are dropped to protect the snapshot
        if (wr_en && !busy_q && offset_q >= sgc_pkg::OFS_GEN && offset_q <= sgc_pkg::OFS_BCNT) begin
            reg_d[offset_q[2:0]] = shift_q & sgc_pkg::wr_mask(offset_q);
        end
        if (busy_q) begin
            prog_cnt_d = prog_cnt_q - PROG_LAST;
            busy_d = (prog_cnt_q != PROG_LAST);
        end else if (prog_start) begin
            busy_d = 1'b1;
            prog_cnt_d = PROG_LOAD;
            nv_d = reg_q;
            // Power down never persists
            nv_d[sgc_pkg::OFS_GEN][sgc_pkg::GEN_PWDN_BIT] = 1'b0;
        end
    end

    // Bank registers; stored copy starts at defaults
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_q <= sgc_pkg::BANK_RST;
            nv_q <= sgc_pkg::BANK_RST;
            busy_q <= 1'b0;
            prog_cnt_q <= '0;
            trig_prev_q <= 1'b0;
        end else begin
            reg_q <= reg_d;
            nv_q <= nv_d;
            busy_q <= busy_d;
            prog_cnt_q <= prog_cnt_d;
            trig_prev_q <= trig_prev_d;
        end
    end

    // Shared pins read as control inputs only outside serial mode
    assign setting = {serial_mode ? 1'b0 : pin14, serial_mode ? 1'b0 : pin15, ctrl0};
    assign state_def = reg_q[sgc_pkg::OFS_SEL][setting] ?
        reg_q[sgc_pkg::OFS_OUT1][sgc_pkg::OUT1_ST1_HI:sgc_pkg::OUT1_ST1_LO] :
        reg_q[sgc_pkg::OFS_OUT1][sgc_pkg::OUT1_ST0_HI:sgc_pkg::OUT1_ST0_LO];

    // Output configuration decode
    always_comb begin
        cfg_d.source_pll = reg_q[sgc_pkg::OFS_OUT1][sgc_pkg::OUT1_SRC_BIT];
        cfg_d.mode = sgc_pkg::sgc_out_mode_t'(state_def);
        cfg_d.power_down = (state_def == sgc_pkg::MODE_PWDN) |
            reg_q[sgc_pkg::OFS_GEN][sgc_pkg::GEN_PWDN_BIT];
        cfg_d.divider = {reg_q[sgc_pkg::OFS_OUT1][sgc_pkg::OUT1_DIVHI_HI:sgc_pkg::OUT1_DIVHI_LO],
            reg_q[sgc_pkg::OFS_DIVLO]};
        cfg_d.divider_run = (cfg_d.divider != 10'h000);
        cfg_d.load_cap_pf = reg_q[sgc_pkg::OFS_XCAP][sgc_pkg::XCAP_HI:sgc_pkg::XCAP_LO];
        if (cfg_d.load_cap_pf > sgc_pkg::LOAD_CAP_MAX) begin
            cfg_d.load_cap_pf = sgc_pkg::LOAD_CAP_MAX;
        end
        cfg_d.input_clk_sel = reg_q[sgc_pkg::OFS_GEN][sgc_pkg::GEN_INCLK_HI:sgc_pkg::GEN_INCLK_LO];
    end

    // Registered configuration
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg_out = cfg_q;
    assign ctrl_setting_out = setting;
    assign serial_mode_out = serial_mode;
    assign nv_prog_in_progress_out = busy_q;
    assign pin15_out = 1'b0;
    // Open drain: only ever pull low, never outside serial mode
    assign pin15_oe_out = drive_q & serial_mode;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_started;
        prog_start ##1 busy_q;
    endsequence
    sequence s_store_done;
        busy_q && prog_cnt_q == PROG_LAST ##1 !busy_q;
    endsequence

    a_store_start: assert property (prog_start |-> s_started ##0 busy_q[*2])
        else $error("store cycle not started on trigger edge");
    a_static_trigger: assert property (!busy_q && trig && trig_prev_q |=> !busy_q)
        else $error("static trigger started a store cycle");
    a_lock_refuse: assert property (!busy_q && nv_lock |=> !busy_q)
        else $error("store cycle ran while locked");
    a_lock_working: assert property (
        !busy_q && trig && !trig_prev_q && !nv_lock &&
        reg_q[sgc_pkg::OFS_GEN][sgc_pkg::GEN_LOCK_BIT] |=> busy_q)
        else $error("working lock bit blocked storing");
    a_status_end: assert property (busy_q && prog_cnt_q == PROG_LAST |-> s_store_done)
        else $error("status did not drop at end of store");
    a_write_now: assert property (wr_en && !busy_q && offset_q == sgc_pkg::OFS_DIVLO
        |=> cfg_d.divider[7:0] == $past(shift_q) ##1 cfg_q.divider[7:0] == $past(shift_q, 2))
        else $error("write did not reach divider");
    a_pins_quiet: assert property (!serial_mode |-> !pin15_oe_out)
        else $error("data pin driven in control pin mode");
    a_tx_msb: assert property (state_q == sgc_pkg::ST_TX && scl_fall && !bus_start &&
        !bus_stop && cnt_q != sgc_pkg::LAST_BIT |=> drive_q == !$past(shift_q[6]))
        else $error("transmit bit order wrong");
    a_div_zero: assert property (cfg_d.divider == 10'h000 |=> !cfg_q.divider_run)
        else $error("zero divider not held");
    a_cap_clamp: assert property (##1 cfg_q.load_cap_pf <= sgc_pkg::LOAD_CAP_MAX)
        else $error("load code above clamp");
endmodule // sgc_config_bank
`default_nettype wire

/* tb/sgc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_host_model (
    // Clock
    input wire logic clk_in,
    // Bus lines
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_out
);
    // Both lines start released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Quarter bit of four clocks, so synchronisers settle
    task automatic step(input int n);
        repeat (n * 4) @(posedge clk_in);
    endtask
    // Data moves only while the clock is low
    task automatic put_bit(input logic b);
        step(1);
        sda_out <= b;
        step(1);
        scl_out <= 1'b1;
        step(2);
        scl_out <= 1'b0;
    endtask
    // Line released, sampled halfway through the high phase
    task automatic get_bit(output logic b);
        step(1);
        sda_out <= 1'b1;
        step(1);
        scl_out <= 1'b1;
        step(1);
        b = sda_line_in;
        step(1);
        scl_out <= 1'b0;
    endtask
    // Start and repeated start
    // Each line moves at most once per edge; data settles while clock is low
    task automatic start();
        step(1);
        sda_out <= 1'b1;
        step(1);
        scl_out <= 1'b1;
        step(2);
        sda_out <= 1'b0;
        step(1);
        scl_out <= 1'b0;
    endtask
    task automatic stop();
        step(1);
        sda_out <= 1'b0;
        step(1);
        scl_out <= 1'b1;
        step(2);
        sda_out <= 1'b1;
        step(2);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ack = ~a;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(last);
    endtask
    // Byte write; callers send zero reserved bits, low offsets, never while storing
    task automatic write_reg(input logic [6:0] dev, input logic [6:0] ofs,
                             input logic [7:0] d, output logic ack);
        logic a1;
        logic a2;
        logic a3;
        start();
        put_byte({dev, 1'b0}, a1);
        put_byte({1'b1, ofs}, a2);
        put_byte(d, a3);
        stop();
        ack = a1 & a2 & a3;
    endtask
    // Byte read, or block read of the count byte and then n further bytes
    task automatic read_reg(input logic [6:0] dev, input logic [6:0] ofs, input int n,
                            output logic [7:0] d, output logic ack);
        logic a1;
        logic a2;
        logic a3;
        logic [7:0] t;
        start();
        put_byte({dev, 1'b0}, a1);
        put_byte({n == 0, ofs}, a2);
        start();
        put_byte({dev, 1'b1}, a3);
        get_byte(n == 0, d);
        for (int i = 0; i < n; i++) get_byte(i == n - 1, t);
        stop();
        ack = a1 & a2 & a3;
    endtask
endmodule // sgc_host_model
`default_nettype wire

/* tb/sgc_config_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_config_bank_bench;
    localparam logic [6:0] DEV = 7'h28; // Upper bits 0Ah, low pair zero
    // Bench state and design pins
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ctrl0 = 1'b0;
    logic gnd = 1'b0;
    logic [6:0] dev = DEV;
    logic [7:0] rd;
    logic ack;
    int err_count = 0;
    int tests_run = 0;
    wire logic scl;
    wire logic sda_host;
    wire logic sda_line;
    wire logic p15;
    wire logic p15_oe;
    wire logic serial;
    wire logic busy;
    wire logic [2:0] setting;
    sgc_pkg::sgc_cfg_t cfg;
    always #20 clk_in = ~clk_in;
    // Open drain data line with pull-up
    assign sda_line = sda_host & (p15_oe ? p15 : 1'b1);
    sgc_config_bank #(.NV_PROG_CYCLES(3000), .DEV_ADDR_HI(5'h0A)) sgc_config_bank_inst (
        .clk_in(clk_in), .reset_in(reset_in), .ctrl_in0_in(ctrl0), .pin14_in(scl),
        .pin15_in(sda_line), .output_supply_gnd_in(gnd), .pin15_out(p15),
        .pin15_oe_out(p15_oe), .cfg_out(cfg), .ctrl_setting_out(setting),
        .serial_mode_out(serial), .nv_prog_in_progress_out(busy));
    sgc_host_model sgc_host_model_inst (
        .clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_out(sda_host));
    // One compare for every value kind
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        sgc_host_model_inst.write_reg(dev, ofs, d, ack);
        check("write ack", 16'h1, {15'h0, ack});
    endtask
    task automatic rd_chk(input logic [6:0] ofs, input int n, input logic [7:0] exp);
        sgc_host_model_inst.read_reg(dev, ofs, n, rd, ack);
        check("read data", {7'h0, 1'b1, exp}, {7'h0, ack, rd});
    endtask
    // Bounded wait for the store flag
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 4000 && busy !== lvl; n++) @(posedge clk_in);
        check("store busy", {15'h0, lvl}, {15'h0, busy});
        if (busy !== lvl) finish_test();
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog against a hung bus
    initial begin
        repeat (90000) @(posedge clk_in);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        check("source", 16'h1, {15'h0, cfg.source_pll});
        check("mode", 16'h1, {14'h0, cfg.mode});
        check("divider", 16'h1, {6'h0, cfg.divider});
        check("load cap", 16'hA, {11'h0, cfg.load_cap_pf});
        rd_chk(7'h02, 0, 8'hB4);
        rd_chk(7'h05, 0, 8'h50);
        rd_chk(7'h06, 0, 8'h60);
        // Load code clamps at twenty
        wr(7'h05, 8'h98);
        check("load cap", 16'h13, {11'h0, cfg.load_cap_pf});
        wr(7'h05, 8'hF8);
        check("load cap", 16'h14, {11'h0, cfg.load_cap_pf});
        // Pin select waits for the stored copy
        wr(7'h02, 8'h7F);
        check("serial mode", 16'h1, {15'h0, serial});
        wr(7'h03, 8'hFF);
        check("divider", 16'h3FF, {6'h0, cfg.divider});
        check("source", 16'h0, {15'h0, cfg.source_pll});
        wr(7'h02, 8'hAC);
        wr(7'h03, 8'h00);
        check("divider run", 16'h0, {15'h0, cfg.divider_run});
        wr(7'h04, 8'h01);
        check("mode", 16'h2, {14'h0, cfg.mode});
        ctrl0 <= 1'b1;
        repeat (8) @(posedge clk_in);
        check("setting", 16'h1, {13'h0, setting});
        check("mode", 16'h3, {14'h0, cfg.mode});
        wr(7'h02, 8'h80);
        check("mode", 16'h0, {14'h0, cfg.mode});
        check("power down", 16'h1, {15'h0, cfg.power_down});
        // Block read: count byte then the bytes
        wr(7'h06, 8'h04);
        rd_chk(7'h04, 2, 8'h02);
        // Address low pair, then grounded supply
        wr(7'h01, 8'h01);
        sgc_host_model_inst.write_reg(DEV, 7'h04, 8'h01, ack);
        check("stale addr", 16'h0, {15'h0, ack});
        dev = DEV | 7'h01;
        rd_chk(7'h01, 0, 8'h01);
        gnd <= 1'b1;
        dev = DEV;
        repeat (8) @(posedge clk_in);
        wr(7'h01, 8'h00);
        // Stored pin select: grounded supply keeps the bus alive
        wr(7'h02, 8'hC0);
        // Store cycles, lock only once stored
        wr(7'h06, 8'h61);
        wait_busy(1'b1);
        rd_chk(7'h01, 0, 8'h40);
        wait_busy(1'b0);
        gnd <= 1'b0;
        repeat (8) @(posedge clk_in);
        check("serial mode", 16'h0, {15'h0, serial});
        check("setting", 16'h7, {13'h0, setting});
        gnd <= 1'b1;
        repeat (8) @(posedge clk_in);
        wr(7'h06, 8'h61);
        check("held trigger", 16'h0, {15'h0, busy});
        wr(7'h06, 8'h60);
        wr(7'h01, 8'h20);
        wr(7'h06, 8'h61);
        wait_busy(1'b1);
        wait_busy(1'b0);
        wr(7'h06, 8'h60);
        wr(7'h06, 8'h61);
        check("locked store", 16'h0, {15'h0, busy});
        wr(7'h03, 8'h55);
        rd_chk(7'h03, 0, 8'h55);
        finish_test();
    end
endmodule // sgc_config_bank_bench
`default_nettype wire
